// ### lep_defs.vh
// timing and reset constants for the leading-edge / long-pulse handshake engine
// assumes a single local clock whose period is given below in whole nanoseconds
`ifndef LEP_DEFS_VH
`define LEP_DEFS_VH

// local clock period
`define LEP_CLK_NS          4

// handshake times in nanoseconds
`define LEP_T_ACK_NS        125
`define LEP_T_REL_NS        150
`define LEP_T_SETUP_NS      25
`define LEP_T_STEP_NS       100

// cycle counts, each minimum rounded up to whole cycles
`define LEP_CYC_ACK         ((`LEP_T_ACK_NS   + `LEP_CLK_NS - 1) / `LEP_CLK_NS)
`define LEP_CYC_REL         ((`LEP_T_REL_NS   + `LEP_CLK_NS - 1) / `LEP_CLK_NS)
`define LEP_CYC_SETUP       ((`LEP_T_SETUP_NS + `LEP_CLK_NS - 1) / `LEP_CLK_NS)
`define LEP_CYC_STEP        ((`LEP_T_STEP_NS  + `LEP_CLK_NS - 1) / `LEP_CLK_NS)

// width of the phase counters, enough for 125 ns + 700 ns
`define LEP_TMR_W           9

// reset values of the configuration shadow
`define LEP_RST_ACK_HIGH    1'b1
`define LEP_RST_REQ_HIGH    1'b1
`define LEP_RST_DELAY       3'h0

`endif

// ### lep_timer.v
// lep_timer: loadable down counter used for every minimum width and spacing
// assumes load values already rounded up to whole clock cycles
`timescale 1ns/1ps

module lep_timer #(
    parameter W = 9
) (
    // clock and reset
    input  wire         mclk,
    input  wire         rst_b,
    // control
    input  wire         load,
    input  wire [W-1:0] load_val,
    // status
    output wire         done
);

    reg [W-1:0] cnt_reg;

    // reset to zero so that a freshly reset engine owes no waiting time
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_reg <= {W{1'b0}};
        end else if (load) begin
            cnt_reg <= load_val;
        end else if (cnt_reg != {W{1'b0}}) begin
            cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
        end
    end

    assign done = (cnt_reg == {W{1'b0}});

endmodule // lep_timer

// ### lep_top.v
// lep_top: leading-edge and long-pulse handshake engine for a parallel port
// assumes pins are synchronous to mclk; settings are plain ports, sampled when idle
//
// Functional notes
// - each side signals readiness by the active-going edge of its handshake line.
// - when receiving, pulse acknowledge each time another input word can be taken.
// - acknowledge lasts at least 125 ns, and longer while request stays active.
// - leading-edge mode puts the settling delay before acknowledge starts.
// - when sending, drive the new word first, then pulse acknowledge.
// - when sending, hold acknowledge while request is still active at width end.
// - without latching, output data settles 25 ns plus delay before acknowledge.
// - acknowledge stays active at least 150 ns after request goes inactive.
// - with latching, next output word appears 0 to 50 ns after request inactive.
// - without latching, output word may change from the request active edge on.
// - long-pulse mode adds the delay to acknowledge width instead of before it.
// - settling delay runs 0 to 700 ns in 100 ns steps, spacing transfers further.
// - acknowledge and request polarities are each selectable.
// - with latching, data is registered on the request edge, not passed through.
`timescale 1ns/1ps
`include "lep_defs.vh"

module lep_top #(
    parameter DW = 32
) (
    // clock and reset
    input  wire          mclk,
    input  wire          rst_b,
    // configuration
    input  wire          cfg_enable,
    input  wire          cfg_long_pulse,
    input  wire          cfg_dir_out,
    input  wire          cfg_ack_act_high,
    input  wire          cfg_req_act_high,
    input  wire          cfg_req_latch,
    input  wire [2:0]    cfg_delay,
    // handshake pins
    input  wire          req_in,
    output reg           ack_out,
    // data pins
    input  wire [DW-1:0] data_in,
    output reg  [DW-1:0] data_out,
    output reg           data_oe_b,
    // receive side toward the user
    input  wire          rx_ready,
    output reg  [DW-1:0] rx_data,
    output reg           rx_valid,
    // transmit side toward the user
    input  wire          tx_valid,
    input  wire [DW-1:0] tx_data,
    output reg           tx_ready,
    // status
    output reg           busy
);

    localparam TW = `LEP_TMR_W;

    localparam [2:0] ST_IDLE     = 3'h0;
    localparam [2:0] ST_LOAD     = 3'h1;
    localparam [2:0] ST_SETTLE   = 3'h2;
    localparam [2:0] ST_ACK      = 3'h3;
    localparam [2:0] ST_WAIT_REQ = 3'h4;
    localparam [2:0] ST_WAIT_REL = 3'h5;

    localparam [TW-1:0] CYC_ACK   = `LEP_CYC_ACK;
    localparam [TW-1:0] CYC_REL   = `LEP_CYC_REL;
    localparam [TW-1:0] CYC_SETUP = `LEP_CYC_SETUP;
    localparam [TW-1:0] CYC_STEP  = `LEP_CYC_STEP;

    // configuration shadow
    reg          long_reg;
    reg          dir_out_reg;
    reg          ack_high_reg;
    reg          req_high_reg;
    reg          latch_reg;
    reg [2:0]    delay_reg;

    reg [2:0]    state_reg;
    reg [2:0]    state_next;
    reg          req_act_d_reg;
    reg          req_seen_reg;
    reg          ack_act_next;

    wire         req_act;
    wire         req_rise;
    wire         req_fall;
    wire         tmr_done;
    wire         rel_done;
    reg          tmr_load;
    reg [TW-1:0] tmr_val;
    wire [TW-1:0] delay_cyc;
    wire [TW-1:0] settle_cyc;
    wire [TW-1:0] width_cyc;
    wire         ack_may_end;
    wire         take_in;
    wire         pre_take;
    reg          pre_reg;

    // polarity is folded in here so the rest of the engine sees active-high
    assign req_act  = req_in ~^ req_high_reg;
    assign req_rise = req_act & ~req_act_d_reg;
    assign req_fall = ~req_act & req_act_d_reg;

    assign delay_cyc = CYC_STEP * {{(TW-3){1'b0}}, delay_reg};

    // delay before acknowledge in leading-edge mode, inside it in long-pulse mode
    assign settle_cyc = (dir_out_reg ? CYC_SETUP : {TW{1'b0}})
                      + (long_reg ? {TW{1'b0}} : delay_cyc);
    assign width_cyc  = CYC_ACK + (long_reg ? delay_cyc : {TW{1'b0}});

    // acknowledge ends only after its width, with request gone for 150 ns
    // the release count is only reloaded on the fall edge, so that cycle must not end ack
    assign ack_may_end = tmr_done & ~req_act & ~req_fall & rel_done;

    // with latching the next word goes out as soon as request is released, even mid-ack
    assign pre_take = dir_out_reg & latch_reg & ~pre_reg & tx_valid & ~req_act
                    & (((state_reg == ST_ACK) & req_seen_reg)
                       | (state_reg == ST_WAIT_REL));

    // first active request edge of this transfer, if in ST_ACK or ST_WAIT_REQ, takes the input word
    assign take_in = ~dir_out_reg & req_rise & ~req_seen_reg
                   & ((state_reg == ST_ACK) | (state_reg == ST_WAIT_REQ));

    lep_timer #(
        .W        (TW)
    ) u_phase (
        .mclk     (mclk),
        .rst_b    (rst_b),
        .load     (tmr_load),
        .load_val (tmr_val),
        .done     (tmr_done)
    );

    // counts the time since request last went inactive
    lep_timer #(
        .W        (TW)
    ) u_release (
        .mclk     (mclk),
        .rst_b    (rst_b),
        .load     (req_fall),
        .load_val (CYC_REL),
        .done     (rel_done)
    );

    always @* begin
        state_next   = state_reg;
        tmr_load     = 1'b0;
        tmr_val      = width_cyc;
        ack_act_next = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (cfg_enable) begin
                    if (cfg_dir_out) begin
                        if (tx_valid) begin
                            state_next = ST_LOAD;
                        end
                    end else if (rx_ready) begin
                        state_next = ST_LOAD;
                    end
                end
            end
            ST_LOAD: begin
                state_next = ST_SETTLE;
                tmr_load   = 1'b1;
                tmr_val    = settle_cyc;
            end
            ST_SETTLE: begin
                if (tmr_done) begin
                    state_next   = ST_ACK;
                    tmr_load     = 1'b1;
                    tmr_val      = width_cyc;
                    ack_act_next = 1'b1;
                end
            end
            ST_ACK: begin
                ack_act_next = 1'b1;
                if (ack_may_end) begin
                    ack_act_next = 1'b0;
                    if (req_seen_reg | req_rise) begin
                        if (dir_out_reg & latch_reg) begin
                            state_next = pre_reg ? ST_LOAD : ST_WAIT_REL;
                        end else begin
                            state_next = ST_IDLE;
                        end
                    end else begin
                        state_next = ST_WAIT_REQ;
                    end
                end
            end
            ST_WAIT_REQ: begin
                if (req_rise) begin
                    state_next = (dir_out_reg & latch_reg) ? ST_WAIT_REL : ST_IDLE;
                end
            end
            ST_WAIT_REL: begin
                // next word goes out only after request is released
                if (~req_act) begin
                    state_next = (pre_reg | pre_take) ? ST_LOAD : ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg     <= ST_IDLE;
            req_act_d_reg <= 1'b0;
            req_seen_reg  <= 1'b0;
            pre_reg       <= 1'b0;
        end else begin
            state_reg     <= state_next;
            req_act_d_reg <= req_act;
            if (pre_take) begin
                pre_reg <= 1'b1;
            end else if (state_reg == ST_LOAD) begin
                pre_reg <= 1'b0;
            end
            // set wins over the clear in ST_LOAD
            if (take_in | (req_rise & ((state_reg == ST_ACK) | (state_reg == ST_SETTLE)))) begin
                req_seen_reg <= 1'b1;
            end else if (state_reg == ST_LOAD) begin
                req_seen_reg <= 1'b0;
            end
        end
    end

    // settings are only taken while idle so a pulse in flight keeps its shape
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            long_reg     <= 1'b0;
            dir_out_reg  <= 1'b0;
            ack_high_reg <= `LEP_RST_ACK_HIGH;
            req_high_reg <= `LEP_RST_REQ_HIGH;
            latch_reg    <= 1'b0;
            delay_reg    <= `LEP_RST_DELAY;
        end else if (state_reg == ST_IDLE) begin
            long_reg     <= cfg_long_pulse;
            dir_out_reg  <= cfg_dir_out;
            ack_high_reg <= cfg_ack_act_high;
            req_high_reg <= cfg_req_act_high;
            latch_reg    <= cfg_req_latch;
            delay_reg    <= cfg_delay;
        end
    end

    // pins and user side, all registered
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ack_out   <= ~`LEP_RST_ACK_HIGH;
            data_out  <= {DW{1'b0}};
            data_oe_b <= 1'b1;
            rx_data   <= {DW{1'b0}};
            rx_valid  <= 1'b0;
            tx_ready  <= 1'b0;
            busy      <= 1'b0;
        end else begin
            ack_out   <= ack_act_next ~^ ack_high_reg;
            data_oe_b <= ~dir_out_reg;
            busy      <= (state_next != ST_IDLE);
            rx_valid  <= take_in;
            tx_ready  <= 1'b0;
            // the word is taken on the request edge itself in both latch settings
            if (take_in) begin
                rx_data <= data_in;
            end
            // word goes to the pins before the settle count starts, or early on release
            if (pre_take | ((state_reg == ST_LOAD) & dir_out_reg & ~pre_reg)) begin
                data_out <= tx_data;
                tx_ready <= 1'b1;
            end
        end
    end

endmodule // lep_top

// ### lep_placeholder_end.v
`timescale 1ns/1ps
// intentionally no module

// ### lep_checker.sv
// lep_checker: pin-level timing of the handshake engine
// assumes settings change only while idle; bound into lep_top below
`timescale 1ns/1ps
module lep_checker #(
    parameter DW = 32
) (
    input wire          mclk, rst_b, cfg_enable, cfg_long_pulse, cfg_dir_out,
    input wire          cfg_ack_act_high, cfg_req_act_high, cfg_req_latch,
    input wire [2:0]    cfg_delay,
    input wire          req_in, ack_out, data_oe_b, rx_valid, tx_valid, tx_ready, busy,
    input wire [DW-1:0] data_in, data_out, rx_data, tx_data
);
    reg       sh_dir, sh_long, sh_ah, sh_rh, sh_lat;
    reg [2:0] sh_dly;
    reg [8:0] c_set, c_wid, c_rel;
    wire      ack_act = ack_out == sh_ah;
    wire      req_act = req_in == sh_rh;

    // settings copied in idle as the engine does; counters saturate
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            {sh_dir, sh_long, sh_ah, sh_rh, sh_lat, sh_dly} <= 8'h30;
            {c_set, c_wid, c_rel} <= {9'h1ff, 9'h0, 9'h1ff};
        end else begin
            if (!busy)
                {sh_dir, sh_long, sh_ah, sh_rh, sh_lat, sh_dly} <= {cfg_dir_out,
                    cfg_long_pulse, cfg_ack_act_high, cfg_req_act_high, cfg_req_latch, cfg_delay};
            c_set <= tx_ready ? 9'h1 : c_set + {8'h0, c_set != 9'h1ff};
            c_wid <= ack_act ? c_wid + {8'h0, c_wid != 9'h1ff} : 9'h0;
            c_rel <= req_act ? 9'h0 : c_rel + {8'h0, c_rel != 9'h1ff};
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    // a polarity reload in idle can flip ack_act for a cycle, hence the settle test
    sequence s_ack_up;
        $rose(ack_act) && busy;
    endsequence
    sequence s_ack_down;
        $fell(ack_act) && $past(sh_ah, 2) == sh_ah;
    endsequence
    property p_setup;
        s_ack_up ##0 sh_dir |-> c_set >= 9'h7 + (sh_long ? 9'h0 : 9'h19 * sh_dly);
    endproperty
    property p_width;
        s_ack_down |-> c_wid >= 9'h20 + (sh_long ? 9'h19 * sh_dly : 9'h0);
    endproperty
    property p_rel;
        s_ack_down |-> c_rel >= 9'h26;
    endproperty
    property p_hold;
        ack_act && req_act && $stable(sh_ah) && $stable(sh_rh) |=> ack_act;
    endproperty
    property p_cap;
        $rose(req_act) && ack_act && busy && !sh_dir
            |-> ##[1:2] (rx_valid && rx_data == $past(data_in));
    endproperty
    property p_pulse;
        rx_valid || tx_ready |=> !rx_valid && !tx_ready;
    endproperty
    property p_word;
        tx_ready |-> data_out == $past(tx_data) && !data_oe_b;
    endproperty
    property p_lat;
        $fell(req_act) && busy && sh_dir && sh_lat && tx_valid |-> ##[1:13] tx_ready;
    endproperty
    property p_idle;
        !busy && !cfg_enable |=> !busy;
    endproperty

    a_setup: assert property (p_setup)
        else $error("ack rose too soon after new data");
    a_width: assert property (p_width)
        else $error("ack pulse too short");
    a_rel: assert property (p_rel)
        else $error("ack ended too soon after request fell");
    a_hold: assert property (p_hold)
        else $error("ack dropped while request active");
    a_cap: assert property (p_cap)
        else $error("input word not captured on request edge");
    a_pulse: assert property (p_pulse)
        else $error("user strobe longer than one cycle");
    a_word: assert property (p_word)
        else $error("output word not driven with tx_ready");
    a_lat: assert property (p_lat)
        else $error("latched output word late after request fell");
    a_idle: assert property (p_idle)
        else $error("transfer started while disabled");
endmodule // lep_checker

bind lep_top lep_checker #(.DW(DW)) u_lep_chk (.mclk, .rst_b, .cfg_enable, .cfg_long_pulse,
    .cfg_dir_out, .cfg_ack_act_high, .cfg_req_act_high, .cfg_req_latch, .cfg_delay, .req_in,
    .ack_out, .data_oe_b, .rx_valid, .tx_valid, .tx_ready, .busy, .data_in, .data_out,
    .rx_data, .tx_data);

// ### lep_periph.sv
// lep_periph: far-side peripheral answering each ack with one request pulse
// assumes its polarity and timing inputs change only between transfers
`timescale 1ns/1ps
module lep_periph #(
    parameter DW = 32
) (
    input  wire          mclk, ack_out, ack_hi, req_hi,
    input  wire [7:0]    lag, hold_c,
    input  wire [DW-1:0] word, data_out,
    output wire          req_in,
    output logic [DW-1:0] data_in, got
);
    logic act;
    logic prev;

    assign req_in = act ? req_hi : !req_hi;
    initial begin
        act = 1'b0;
        prev = 1'b0;
        data_in = '0;
        got = '0;
        forever begin
            @(negedge mclk);
            // answer only a real leading edge, not a polarity swap seen before ack follows
            if (ack_out === ack_hi && prev !== ack_out) begin
                got = data_out;
                data_in = word;
                repeat (lag) @(negedge mclk);
                act = 1'b1;
                repeat (hold_c) @(negedge mclk);
                act = 1'b0;
                for (int i = 0; i < 600 && ack_out === ack_hi; i++) @(negedge mclk);
                // inverse after release so a late sample cannot pass
                data_in = ~word;
            end
            prev = ack_out;
        end
    end
endmodule // lep_periph

// ### test_lep_top.sv
// test_lep_top: directed handshake scenarios in both directions
// assumes lep_periph answers each ack on the far side
`timescale 1ns/1ps
module test_lep_top;
    localparam DW = 32;
    logic          mclk, rst_b, cfg_enable, cfg_long_pulse, cfg_dir_out, cfg_req_latch;
    logic          cfg_ack_act_high, cfg_req_act_high, rx_ready, tx_valid;
    logic [2:0]    cfg_delay;
    logic [7:0]    lag, hold_c;
    logic [DW-1:0] word, tx_data;
    wire           req_in, ack_out, data_oe_b, rx_valid, tx_ready, busy;
    wire  [DW-1:0] data_in, data_out, rx_data, got;
    int            error_cnt, n_tests, n;

    lep_top #(.DW(DW)) DUT (.mclk, .rst_b, .cfg_enable, .cfg_long_pulse, .cfg_dir_out,
        .cfg_ack_act_high, .cfg_req_act_high, .cfg_req_latch, .cfg_delay, .req_in, .ack_out,
        .data_in, .data_out, .data_oe_b, .rx_ready, .rx_data, .rx_valid, .tx_valid,
        .tx_data, .tx_ready, .busy);
    lep_periph #(.DW(DW)) u_periph (.mclk, .ack_out, .ack_hi(cfg_ack_act_high),
        .req_hi(cfg_req_act_high), .lag, .hold_c, .word, .data_out, .req_in, .data_in, .got);

    task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        if (error_cnt == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    function automatic logic sig(input int k);
        case (k)
            0: return tx_ready;
            1: return rx_valid;
            2: return !busy && ack_out !== cfg_ack_act_high;
            4: return ack_out !== cfg_ack_act_high;
            default: return ack_out === cfg_ack_act_high;
        endcase
    endfunction

    task automatic wait_sig(input int k);
        for (n = 0; sig(k) !== 1'b1; n++) begin
            @(negedge mclk);
            if (n > 3000) begin
                error_cnt++;
                tally_and_finish;
            end
        end
    endtask

    // polarity, mode and delay all vary with i, so 0..7 covers every delay step
    task automatic cfgset(input int i, input logic d);
        cfg_dir_out = d;
        cfg_delay = i[2:0];
        cfg_long_pulse = i[0];
        cfg_req_latch = i[1];
        cfg_ack_act_high = !i[2];
        cfg_req_act_high = i[1] ^ i[2];
        lag = 8'(3 * i);
        hold_c = 8'(20 + 8 * i);
        word = DW'(32'h1357_9bdf * (i + 1)) ^ {DW{d}};
        repeat (4) @(negedge mclk);
    endtask

    task automatic t_out(input int i);
        logic b2b;
        cfgset(i, 1'b1);
        b2b = cfg_req_latch & !cfg_long_pulse;
        tx_data = word;
        tx_valid = 1'b1;
        wait_sig(0);
        check(data_out, word);
        check(DW'(data_oe_b), DW'(0));
        tx_valid = b2b;
        tx_data = ~word;
        wait_sig(3);
        check(DW'(n >= 7 + (cfg_long_pulse ? 0 : 25 * cfg_delay)), DW'(1));
        if (b2b) begin
            wait_sig(0);
            tx_valid = 1'b0;
            check(data_out, ~word);
        end
        wait_sig(2);
        check(got, b2b ? ~word : word);
    endtask

    task automatic t_in(input int i);
        cfgset(i, 1'b0);
        rx_ready = 1'b1;
        wait_sig(1);
        rx_ready = 1'b0;
        check(rx_data, word);
        check(DW'(data_oe_b), DW'(1));
        wait_sig(2);
    endtask

    task automatic t_cfg;
        cfgset(7, 1'b1);
        cfg_enable = 1'b0;
        tx_valid = 1'b1;
        repeat (40) @(negedge mclk);
        check(DW'(busy), DW'(0));
        cfg_enable = 1'b1;
        wait_sig(0);
        tx_valid = 1'b0;
        cfg_delay = 3'h0;
        cfg_long_pulse = 1'b0;
        wait_sig(3);
        wait_sig(4);
        check(DW'(n >= 32 + 25 * 7), DW'(1));
        wait_sig(2);
    endtask

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    initial begin
        error_cnt = 0;
        n_tests = 0;
        rst_b = 1'b0;
        cfg_enable = 1'b1;
        rx_ready = 1'b0;
        tx_valid = 1'b0;
        tx_data = '0;
        cfgset(0, 1'b0);
        repeat (4) @(negedge mclk);
        check(DW'(ack_out), DW'(0));
        rst_b = 1'b1;
        for (int i = 0; i < 8; i++) begin
            t_out(i);
            t_in(i);
        end
        t_cfg;
        tally_and_finish;
    end
endmodule // test_lep_top
